/* hdl/sba_agent.sv */
// Arbitration agent for one symmetric master on a shared four-agent bus.
// Assumes all inputs synchronous to sys_clk_i; pins already converted to active high.
// Identity comes from the request pins in the first enabled clock after reset release.
// Pin drivers and the wired-OR stall line resolution sit outside this block.

// Behaviour
// - All state captured on the rising bus clock edge; stall and issue outputs also follow inputs directly.
// - Agent drives only its own request line, reads the others.
// - Request pins sampled at reset release fix the agent identifier.
// - Rotating identifier starts at three after reset.
// - Arbitration event on request into idle bus or owner release.
// - New owner computed round-robin from sampled lines and rotating identifier.
// - Rotating identifier loads the new owner identifier after each event.
// - Owner parks by holding its request while it wants the bus and nobody else requests.
// - Owner drops its request as soon as another request is seen.
// - A requester keeps its request until it becomes owner.
// - After deassertion the request stays low at least one clock.
// - Parity error, reset or bus init force the request low next clock.
// - Requests resume after reset release, or three clocks after bus init.
// - After parity error locked agent re-requests in two clocks, else waits four.
// - Observed priority request stops new requests except locked ones.
// - Stall line asserted when busy; owner issues nothing during a stall.
// - Stall line driven and sampled only on designated clocks.
// - Observed bus init resets state and rotating identifier, keeps caches.
// - If enabled, bus init is driven on an unreliable bus condition.
// - If enabled, observed parity error aborts the transaction in progress.
module sba_agent (
    input wire logic sys_clk_i,                        // Bus clock
    input wire logic srst_i,                           // Synchronous reset, high
    input wire logic clk_en_i,                         // Clock enable, freezes all state
    input wire logic [1:0] request_pins_i,             // Request pins, sampled at reset release
    input wire logic [3:0] sym_request_lines_i,        // All four bus request lines
    input wire sba_pkg::sba_bus_obs_s obs_i,           // Observed priority, stall, init, parity
    input wire sba_pkg::sba_cfg_s cfg_i,               // Power-on configuration options
    input wire logic want_bus_i,                       // Core wants a transaction
    input wire logic locked_i,                         // Core is inside a locked operation
    input wire logic busy_i,                           // Core cannot accept new transactions
    input wire logic bus_fault_i,                      // Core saw an unreliable bus condition
    output logic own_request_line_o,                   // Own request line drive
    output logic [1:0] agent_id_o,                     // Agent identifier
    output logic [1:0] rot_id_o,                       // Rotating identifier
    output logic [1:0] owner_id_o,                     // Current symmetric owner
    output logic is_owner_o,                           // This agent owns the bus
    output logic may_issue_o,                          // Owner may issue a new transaction
    output logic abort_o,                              // Abort transaction in progress
    output logic bnr_drive_o,                          // Stall line output value
    output logic bnr_oe_o,                             // Stall line output enable
    output logic bus_initialize_drive_o,                        // Bus init output value
    output logic bus_initialize_oe_o,                           // Bus init output enable
    output logic flush_state_o                         // Pulse: in-flight state discarded
);
    import sba_pkg::*;

    // Arbitration and request state
    sba_state_e state_r, state_nxt;
    logic [1:0] agent_id_r;
    logic [1:0] rot_id_r, rot_id_nxt;
    logic [1:0] owner_r, owner_nxt;
    logic [3:0] req_prev_r;
    logic in_reset_r;
    logic req_r, req_nxt;
    logic [2:0] hold_r, hold_nxt;

    // Stall, abort and side outputs
    logic bnr_phase_r;
    logic stall_r;
    logic abort_r;
    logic bus_initialize_out_r;
    logic flush_r;

    // Decoded conditions
    wire bus_initialize_seen = obs_i.bus_initialize & cfg_i.bus_initialize_observe_en;
    wire addr_parity_error_seen = obs_i.addr_parity_error & cfg_i.addr_parity_error_observe_en;
    wire [3:0] lines_now = sym_request_lines_i;
    logic [3:0] own_mask;
    logic [3:0] other_lines;
    wire others_req = |other_lines;
    wire bus_was_idle = ~|req_prev_r;
    wire owner_released = req_prev_r[owner_r] & ~lines_now[owner_r];
    // Event on first request into an idle bus or on the owner's release
    wire arb_event = (bus_was_idle & |lines_now) | owner_released;
    // Locked work may still request under a priority hold
    wire pri_block = obs_i.priority_request & ~locked_i;
    wire owner_now = (state_r == SBA_OWNER);
    wire [1:0] pick;
    wire pick_any;

    // Request decisions
    wire [2:0] hold_dec = (hold_r != 3'h0) ? hold_r - 3'h1 : hold_r;
    wire start_req = want_bus_i & ~pri_block & (hold_r == 3'h0);
    wire won_event = arb_event & pick_any & (pick == agent_id_r);
    wire must_yield = others_req | ~want_bus_i;

    // Split each request line into own and foreign
    for (genvar g = 0; g < 4; g++) begin : g_line
        assign own_mask[g] = (agent_id_r == 2'(g));
        assign other_lines[g] = lines_now[g] & ~own_mask[g];
    end

    // Round-robin winner from sampled lines
    sba_rr_pick u_pick (
        .req_i(lines_now),
        .rot_id_i(rot_id_r),
        .winner_o(pick),
        .any_o(pick_any)
    );

    // Rotating identifier and owner tracking
    always_comb begin
        rot_id_nxt = rot_id_r;
        owner_nxt = owner_r;
        if (arb_event && pick_any) begin
            rot_id_nxt = pick;
            owner_nxt = pick;
        end
    end

    // Request state machine with recovery holds
    always_comb begin
        state_nxt = state_r;
        req_nxt = req_r;
        // Hold counter runs down in every state; recovery entries reload it
        hold_nxt = hold_dec;
        unique case (state_r)
            SBA_IDLE: begin
                if (start_req) begin
                    req_nxt = 1'b1;
                    state_nxt = SBA_REQUEST;
                end
            end
            SBA_REQUEST: begin
                req_nxt = 1'b1;
                if (won_event) begin
                    state_nxt = SBA_OWNER;
                end
            end
            SBA_OWNER: begin
                if (must_yield) begin
                    req_nxt = 1'b0;
                    hold_nxt = REQ_GAP_CLKS;
                    state_nxt = SBA_HOLDOFF;
                end else begin
                    req_nxt = 1'b1;
                end
            end
            SBA_HOLDOFF: begin
                req_nxt = 1'b0;
                if (hold_nxt == 3'h0) begin
                    state_nxt = SBA_IDLE;
                end
            end
        endcase
        // Error and initialization overrides
        if (addr_parity_error_seen) begin
            req_nxt = 1'b0;
            state_nxt = SBA_HOLDOFF;
            hold_nxt = locked_i ? ADDR_PARITY_ERROR_LOCK_CLKS : ADDR_PARITY_ERROR_IDLE_CLKS;
        end
        if (bus_initialize_seen) begin
            req_nxt = 1'b0;
            state_nxt = SBA_HOLDOFF;
            hold_nxt = BUS_INITIALIZE_HOLD_CLKS;
        end
    end

    // Identity decode: pin zero wins, then pin one, else agent zero
    wire [1:0] id_from_pins = request_pins_i[0] ? 2'h0 :
                              (request_pins_i[1] ? 2'h1 : 2'h0);
    // Identity clock freezes arbitration so the strap cannot start an event
    wire run_normal = ~in_reset_r;
    // Bus init restores the rotating identifier and forgets line history
    wire [1:0] rot_id_upd = bus_initialize_seen ? ROT_ID_RST : rot_id_nxt;
    wire [1:0] owner_upd = bus_initialize_seen ? ROT_ID_RST : owner_nxt;
    wire [3:0] req_prev_upd = (in_reset_r | bus_initialize_seen) ? 4'h0 : lines_now;

    // Reset tracker: high through reset and for the identity clock
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            in_reset_r <= 1'b1;
        end else if (clk_en_i) begin
            in_reset_r <= 1'b0;
        end
    end

    // Identity capture in the first enabled clock after release
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            agent_id_r <= 2'h0;
        end else if (clk_en_i && in_reset_r) begin
            agent_id_r <= id_from_pins;
        end
    end

    // Rotating identifier and owner
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rot_id_r <= ROT_ID_RST;
            owner_r <= ROT_ID_RST;
        end else if (clk_en_i && run_normal) begin
            rot_id_r <= rot_id_upd;
            owner_r <= owner_upd;
        end
    end

    // Request line history for arbitration event detection
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            req_prev_r <= 4'h0;
        end else if (clk_en_i) begin
            req_prev_r <= req_prev_upd;
        end
    end

    // Request state register
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_r <= SBA_IDLE;
        end else if (clk_en_i && run_normal) begin
            state_r <= state_nxt;
        end
    end

    // Request line drive and recovery hold counter
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            req_r <= 1'b0;
            hold_r <= 3'h0;
        end else if (clk_en_i && run_normal) begin
            req_r <= req_nxt;
            hold_r <= hold_nxt;
        end
    end

    // Stall phase: even clocks counted from reset release are designated
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            bnr_phase_r <= 1'b0;
        end else if (clk_en_i) begin
            bnr_phase_r <= ~bnr_phase_r;
        end
    end

    // Stall line sampled only on designated clocks, honoured from the next
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            stall_r <= 1'b0;
        end else if (clk_en_i && !bnr_phase_r) begin
            stall_r <= obs_i.block_next_request;
        end
    end

    // Abort pulse for each clock of observed parity error
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            abort_r <= 1'b0;
        end else if (clk_en_i) begin
            abort_r <= addr_parity_error_seen;
        end
    end

    // Bus init drive from the core's fault flag, when enabled
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            bus_initialize_out_r <= 1'b0;
        end else if (clk_en_i) begin
            bus_initialize_out_r <= bus_fault_i & cfg_i.bus_initialize_drive_en;
        end
    end

    // Flush pulse the clock after an observed bus init
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            flush_r <= 1'b0;
        end else if (clk_en_i) begin
            flush_r <= bus_initialize_seen;
        end
    end

    // Request and identity outputs
    assign own_request_line_o = req_r;
    assign agent_id_o = agent_id_r;
    assign rot_id_o = rot_id_r;
    assign owner_id_o = owner_r;

    // Ownership and issue permission
    assign is_owner_o = owner_now;
    assign may_issue_o = owner_now & ~stall_r & ~pri_block & ~abort_r;

    // Recovery outputs
    assign abort_o = abort_r;
    assign bnr_drive_o = busy_i & ~bnr_phase_r;
    assign bnr_oe_o = busy_i & ~bnr_phase_r;
    assign bus_initialize_drive_o = bus_initialize_out_r;
    assign bus_initialize_oe_o = bus_initialize_out_r;
    assign flush_state_o = flush_r;

    // Stall and bus init drive pins follow in the side output group above

endmodule // sba_agent

/* hdl/sba_pkg.sv */
// Package for the symmetric bus arbitration agent: types, widths and timing counts.
// Assumes a single bus clock; all bus signals here are active high after pin inversion.
package sba_pkg;

    localparam int unsigned NUM_AGENTS = 4;
    localparam int unsigned ID_W = 2;

    // Rotating identifier after reset or bus initialization
    localparam logic [1:0] ROT_ID_RST = 2'h3;

    // Recovery counts in bus clocks
    localparam logic [2:0] BUS_INITIALIZE_HOLD_CLKS = 3'h3;
    localparam logic [2:0] ADDR_PARITY_ERROR_LOCK_CLKS = 3'h2;
    localparam logic [2:0] ADDR_PARITY_ERROR_IDLE_CLKS = 3'h4;
    localparam logic [2:0] REQ_GAP_CLKS = 3'h1;

    // Observed bus condition group
    typedef struct packed {
        logic priority_request;
        logic block_next_request;
        logic bus_initialize;
        logic addr_parity_error;
    } sba_bus_obs_s;

    // Power-on configuration options
    typedef struct packed {
        logic bus_initialize_observe_en;
        logic bus_initialize_drive_en;
        logic addr_parity_error_observe_en;
    } sba_cfg_s;

    typedef enum logic [1:0] {
        SBA_IDLE,
        SBA_REQUEST,
        SBA_OWNER,
        SBA_HOLDOFF
    } sba_state_e;

endpackage : sba_pkg

/* hdl/sba_rr_pick.sv */
// Round-robin winner selection among four symmetric request lines.
// Assumes requests are sampled bus lines; purely combinational.
module sba_rr_pick (
    input wire logic [3:0] req_i,      // Sampled symmetric request lines
    input wire logic [1:0] rot_id_i,   // Lowest-priority agent identifier
    output logic [1:0] winner_o,       // Selected owner
    output logic any_o                 // At least one request present
);
    import sba_pkg::*;

    // Search starts one past the rotating identifier
    always_comb begin
        logic [1:0] idx;
        logic found;
        idx = 2'h0;
        found = 1'b0;
        winner_o = rot_id_i;
        for (int k = 1; k <= 4; k++) begin
            idx = rot_id_i + k[1:0];
            if (!found && req_i[idx]) begin
                winner_o = idx;
                found = 1'b1;
            end
        end
    end

    assign any_o = |req_i;

endmodule // sba_rr_pick

/* dv/sba_agent_properties.sv */
// Checker for the arbitration agent: request timing, recovery and ownership.
// Assumes it is bound to sba_agent and sees only that module's ports.
module sba_agent_properties (
    input wire logic sys_clk_i, // Bus clock
    input wire logic srst_i, // Reset
    input wire logic [3:0] sym_request_lines_i, // Request lines
    input wire sba_pkg::sba_bus_obs_s obs_i, // Bus conditions
    input wire sba_pkg::sba_cfg_s cfg_i, // Options
    input wire logic want_bus_i, // Core wants bus
    input wire logic locked_i, // Locked operation
    input wire logic own_request_line_o, // Own request
    input wire logic [1:0] agent_id_o, // Identifier
    input wire logic [1:0] rot_id_o, // Rotating identifier
    input wire logic is_owner_o, // Owner flag
    input wire logic abort_o, // Abort pulse
    input wire logic flush_state_o, // Flush pulse
    input wire logic may_issue_o, // Issue permission
    input wire logic bnr_oe_o // Stall drive enable
);
    timeunit 1ns;
    timeprecision 1ps;
    import sba_pkg::*;
    logic ini, aer, oth, req;
    // Qualified recovery events and requests from the other agents
    assign ini = obs_i.bus_initialize & cfg_i.bus_initialize_observe_en;
    assign aer = obs_i.addr_parity_error & cfg_i.addr_parity_error_observe_en;
    assign oth = |(sym_request_lines_i & ~(4'h1 << agent_id_o));
    assign req = own_request_line_o;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    a_init_req_off: assert property (ini |=> !req [*3]) else $error("init req");
    a_init_rot: assert property (ini |=> rot_id_o == ROT_ID_RST && flush_state_o)
        else $error("init rot");
    a_addr_parity_error_quiet: assert property (aer && !locked_i |=> abort_o ##0 !req [*4])
        else $error("parity quiet");
    a_req_gap: assert property ($fell(req) |=> !req) else $error("req gap");
    a_req_holds: assert property (req && !is_owner_o && !ini && !aer |=> req)
        else $error("req withdrawn");
    a_owner_yields: assert property (is_owner_o && req && oth |=> !req) else $error("yield");
    a_owner_parks: assert property (is_owner_o && req && want_bus_i && !oth && !ini && !aer
        && !obs_i.priority_request |=> req) else $error("park");
    a_prio_blocks: assert property (obs_i.priority_request && !locked_i && !req |=> !req)
        else $error("prio req");
    a_prio_no_issue: assert property (obs_i.priority_request && !locked_i |-> !may_issue_o)
        else $error("prio issue");
    a_stall_alternate: assert property (bnr_oe_o |=> !bnr_oe_o)
        else $error("stall phase");
endmodule // sba_agent_properties

bind sba_agent sba_agent_properties sba_agent_properties_i (.*);

/* dv/sba_peer_model.sv */
// Partner model: peer symmetric agent one and the central agent's reset strap.
// Assumes the block is agent zero and lines 3:2 have no agent fitted.
module sba_peer_model (
    input wire logic sys_clk_i, // Bus clock
    input wire logic srst_i, // Reset, high
    input wire logic own_req_i, // Block's request line
    input wire logic peer_want_i, // Peer wants the bus
    output logic [3:0] lines_o, // Request lines
    output logic [1:0] pins_o // Block's request pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic peer_req_r, strap_r;
    // Peer line drops in reset; strap lasts one clock past release
    always_ff @(posedge sys_clk_i) begin
        peer_req_r <= peer_want_i & ~srst_i;
        strap_r <= srst_i;
    end
    // Unfitted lines sit inactive; pins follow the lines once strapping ends
    assign lines_o = {2'h0, peer_req_r, own_req_i};
    assign pins_o = strap_r ? 2'h1 : lines_o[1:0];
endmodule // sba_peer_model

/* dv/sba_agent_tb.sv */
// Testbench for the arbitration agent beside one peer agent.
// Assumes the block is agent zero; inputs change on the falling clock edge.
module sba_agent_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sba_pkg::*;
    logic sys_clk_i = 1'b0, srst_i = 1'b1, clk_en_i = 1'b1, want_bus_i = 1'b0, locked_i = 1'b0;
    logic busy_i = 1'b0, bus_fault_i = 1'b0, peer_want = 1'b0, own_request_line_o, is_owner_o;
    logic may_issue_o, abort_o, bnr_drive_o, bnr_oe_o, bus_initialize_drive_o, bus_initialize_oe_o, flush_state_o;
    logic [3:0] sym_request_lines_i;
    logic [1:0] request_pins_i, agent_id_o, rot_id_o, owner_id_o;
    sba_bus_obs_s obs_i = '0;
    sba_cfg_s cfg_i = 3'h7;
    int err_total = 0, n_checks = 0;
    // Bus clock at 125 MHz
    always #4 sys_clk_i = ~sys_clk_i;
    // Peer agent with strap, and the block
    sba_peer_model sba_peer_model_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .own_req_i(own_request_line_o), .peer_want_i(peer_want), .lines_o(sym_request_lines_i),
        .pins_o(request_pins_i));
    sba_agent sba_agent_i (.*);
    // Compare, step and bounded wait helpers
    task automatic chk(input string what, input logic [3:0] seen, exp);
        n_checks++;
        if (seen !== exp) err_total++;
        if (seen !== exp) $display("unexpected %s expected %h seen %h", what, exp, seen);
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wait_req(input logic lvl);
        for (int k = 0; own_request_line_o !== lvl; k++) begin
            if (k == 12) err_total++;
            if (k == 12) close_out;
            tick(1);
        end
    endtask
    // Win an idle bus, hold through a stall, yield to the peer and win back
    task automatic s_own;
        tick(2);
        chk("reset ids", {agent_id_o, rot_id_o}, 4'h3);
        want_bus_i = 1'b1;
        wait_req(1'b1);
        tick(1);
        chk("owner", {owner_id_o, rot_id_o}, 4'h0);
        chk("is owner", {is_owner_o, may_issue_o}, 4'h3);
        obs_i.block_next_request = 1'b1;
        busy_i = 1'b1;
        tick(3);
        chk("issue", may_issue_o, 4'h0);
        chk("stall off phase", {bnr_drive_o, bnr_oe_o}, 4'h0);
        obs_i.block_next_request = 1'b0;
        peer_want = 1'b1;
        tick(3);
        chk("yield", own_request_line_o, 4'h0);
        chk("not owner", is_owner_o, 4'h0);
        chk("stall on phase", {bnr_drive_o, bnr_oe_o}, 4'h3);
        tick(4);
        chk("peer owns", {owner_id_o, rot_id_o}, 4'h5);
        chk("waiting", own_request_line_o, 4'h1);
        peer_want = 1'b0;
        tick(3);
        chk("won back", {owner_id_o, rot_id_o}, 4'h0);
    endtask
    // Bus init, then parity errors locked and unlocked, while holding the bus
    task automatic s_recover;
        obs_i.bus_initialize = 1'b1;
        tick(1);
        obs_i.bus_initialize = 1'b0;
        chk("init", {flush_state_o, own_request_line_o, rot_id_o}, 4'hb);
        wait_req(1'b1);
        for (int lk = 1; lk >= 0; lk--) begin
            locked_i = lk[0];
            tick(2);
            obs_i.addr_parity_error = 1'b1;
            tick(1);
            obs_i.addr_parity_error = 1'b0;
            chk("parity", {abort_o, own_request_line_o}, 4'h2);
            wait_req(1'b1);
        end
    endtask
    // Priority agent holds off new requests except locked ones; fault drives init
    task automatic s_prio;
        want_bus_i = 1'b0;
        obs_i.priority_request = 1'b1;
        tick(4);
        want_bus_i = 1'b1;
        tick(3);
        chk("held off", own_request_line_o, 4'h0);
        locked_i = 1'b1;
        bus_fault_i = 1'b1;
        wait_req(1'b1);
        chk("locked req", {bus_initialize_drive_o, bus_initialize_oe_o, own_request_line_o}, 4'h7);
    endtask
    // Reset for 20 clocks, then each scenario in turn
    initial begin
        tick(20);
        srst_i = 1'b0;
        s_own;
        s_recover;
        s_prio;
        close_out;
    end
endmodule // sba_agent_tb
